// *** eq_adapt.sv ***
// boost table walk of one channel: picks the entry with the best figure of merit, then freezes
`timescale 1ns/10ps
`include "quad_xp_map.svh"
module eq_adapt
	import quad_xp_pkg::*;
#(
	parameter int SETTLE = `EQ_SETTLE_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        enable,
	input  wire logic [4:0]  len_m1,
	input  wire logic [7:0]  figure_of_merit,
	input  wire stage_code_t entry,
	output logic      [4:0]  idx,
	output stage_code_t      code,
	output logic             busy,
	output logic             done
);
	adapt_state_e state_r;
	logic [7:0]   cnt_r;
	logic [7:0]   best_fom_r;
	stage_code_t  best_code_r;

	// walk: apply entry, settle, score, keep the best
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= ADAPT_IDLE;
			idx         <= 5'h00;
			code        <= `TABLE_RESET_ENTRY;
			cnt_r       <= 8'h00;
			best_fom_r  <= 8'h00;
			best_code_r <= `TABLE_RESET_ENTRY;
		end else if (start && enable) begin
			state_r    <= ADAPT_STEP;
			idx        <= 5'h00;
			best_fom_r <= 8'h00;
		end else begin
			case (state_r)
				ADAPT_STEP: begin
					code    <= entry;
					cnt_r   <= 8'(SETTLE);
					state_r <= ADAPT_SETTLE;
				end
				ADAPT_SETTLE: begin
					if (cnt_r > 8'h01) begin
						cnt_r <= cnt_r - 8'h01;
					end else begin
						if (idx == 5'h00 || figure_of_merit > best_fom_r) begin
							best_fom_r  <= figure_of_merit;
							best_code_r <= code;
						end
						if (idx >= len_m1) begin
							state_r <= ADAPT_FROZEN;
							code    <= (idx == 5'h00 || figure_of_merit > best_fom_r) ? code : best_code_r;
						end else begin
							idx     <= idx + 5'h01;
							state_r <= ADAPT_STEP;
						end
					end
				end
				ADAPT_FROZEN: state_r <= ADAPT_FROZEN;
				ADAPT_IDLE:   state_r <= ADAPT_IDLE;
				default:      state_r <= ADAPT_IDLE;
			endcase
		end
	end

	assign busy = (state_r == ADAPT_STEP) || (state_r == ADAPT_SETTLE);
	assign done = (state_r == ADAPT_FROZEN);
endmodule

// *** link_partner.sv ***
// far-end transmitters: input energy per lane and a figure of merit seen through each equalizer
`timescale 1ns/10ps
module link_partner (
	input  wire logic [3:0]  active,
	input  wire logic [31:0] eq_stage_code,
	output logic      [3:0]  sig_present,
	output logic      [31:0] figure_of_merit
);
	// a silent transmitter leaves no energy on its lane
	assign sig_present = active;
	// eye quality grows with the total boost of the four stages
	always_comb begin
		figure_of_merit = 32'h0;
		for (int i = 0; i < 16; i++)
			figure_of_merit[8*(i/4)+:8] += 8'(eq_stage_code[2*i+:2]);
	end
endmodule

// *** quad_crosspoint_eq_control.sv ***
// control of one quad: crosspoint routing, boost table adaptation and signal-detect gating
`timescale 1ns/10ps
`include "quad_xp_map.svh"
module quad_crosspoint_eq_control
	import quad_xp_pkg::*;
#(
	parameter int NCH    = 4,
	parameter int SETTLE = `EQ_SETTLE_CYC
) (
	input  wire logic              clock,
	input  wire logic              reset_n,
	// register port of the channel register sets
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [1:0]        reg_chan,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	output logic                   reg_rvalid,
	// analog front end and recovery loops
	input  wire logic [NCH-1:0]    sig_present,
	input  wire logic [NCH-1:0]    lock_acq,
	input  wire logic [NCH*8-1:0]  figure_of_merit,
	output logic      [NCH-1:0]    path_power_on,
	output logic      [NCH*8-1:0]  eq_stage_code,
	output logic      [NCH*2-1:0]  eq_bandwidth,
	output logic      [NCH-1:0]    eq_limiting,
	output logic      [NCH*2-1:0]  data_mux_sel,
	output logic      [NCH-1:0]    local_buf_en,
	output logic      [NCH-1:0]    multi_buf_en,
	output logic      [NCH-1:0]    xp_enable,
	output logic      [NCH-1:0]    master_ctl,
	output logic      [NCH-1:0]    recovery_loop_reset
);
	logic        rst_n;
	logic [NCH-1:0] sig_s;

	// channel register state
	logic [7:0]  cdr_rst_r   [NCH];
	logic [7:0]  sig_det_r   [NCH];
	logic [7:0]  eq_ctl_r    [NCH];
	logic [4:0]  tbl_len_r   [NCH];
	logic [7:0]  xp_path_r   [NCH];
	logic [7:0]  cbus_sel_r  [NCH];
	stage_code_t boost_table [NCH][32];
	logic [NCH-1:0] readapt_r;
	logic [NCH-1:0] rl_rst_d_r;
	logic [NCH-1:0] lock_acq_d_r;

	// adaptation engines, one per channel register set
	logic [4:0]  ad_idx   [NCH];
	stage_code_t ad_code  [NCH];
	logic [NCH-1:0] ad_busy;
	logic [NCH-1:0] ad_done;
	logic [NCH-1:0] ad_start;
	logic [NCH-1:0] ad_enable;
	logic [NCH-1:0] rl_rst_now;

	// owner of each physical equalizer's control bus
	logic [1:0]  owner    [NCH];
	logic [NCH-1:0] owned;

	logic [1:0]  wr_ch;
	logic [7:0]  rd_value;

	// reset release and pin synchronisers
	sync2 #(.W(1)) u_rst_sync (
		.clock (clock),
		.rst_n (reset_n),
		.d     (1'b1),
		.q     (rst_n)
	);

	sync2 #(.W(NCH)) u_sig_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (sig_present),
		.q     (sig_s)
	);

	assign wr_ch = reg_chan;

	// writable control registers of each channel
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < NCH; c++) begin
				cdr_rst_r[c]  <= 8'h00;
				sig_det_r[c]  <= 8'h00;
				eq_ctl_r[c]   <= {6'h00, `BW_FULL_RATE};
				tbl_len_r[c]  <= `TABLE_LEN_RESET;
				xp_path_r[c]  <= {2'h0, 2'(c), 4'h0}; // mux field starts on the own channel
				cbus_sel_r[c] <= {6'h00, 2'(c)};
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_CDR_RESET:    cdr_rst_r[wr_ch]  <= reg_wdata;
				`REG_SIG_DETECT:   sig_det_r[wr_ch]  <= reg_wdata;
				`REG_EQ_CONTROL:   eq_ctl_r[wr_ch]   <= reg_wdata & 8'hf7;
				`REG_TABLE_LENGTH: tbl_len_r[wr_ch]  <= reg_wdata[4:0];
				`REG_XP_PATH:      xp_path_r[wr_ch]  <= reg_wdata;
				`REG_CTRL_BUS_SEL: cbus_sel_r[wr_ch] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// boost table: thirty-two entries per channel, any stage combination
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < NCH; c++) begin
				for (int e = 0; e < 32; e++) begin
					boost_table[c][e] <= `TABLE_RESET_ENTRY;
				end
			end
		end else if (reg_wr && reg_addr >= `REG_TABLE_FIRST && reg_addr <= `REG_TABLE_LAST) begin
			boost_table[wr_ch][reg_addr[4:0]] <= reg_wdata;
		end
	end

	// manual readapt command is a one-cycle pulse from the self-clearing bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readapt_r <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				readapt_r[c] <= reg_wr && reg_addr == `REG_EQ_CONTROL && wr_ch == 2'(c)
					&& reg_wdata[`EQC_READAPT_BIT];
			end
		end
	end

	// edge history of recovery loop reset and lock acquisition
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rl_rst_d_r   <= '0;
			lock_acq_d_r <= '0;
		end else begin
			rl_rst_d_r   <= rl_rst_now;
			lock_acq_d_r <= lock_acq;
		end
	end

	// adaptation starts on reset release, reacquisition or readapt
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			rl_rst_now[c] = |cdr_rst_r[c][`CDR_RST_HI:`CDR_RST_LO];
			ad_start[c]   = (rl_rst_d_r[c] && !rl_rst_now[c])
				|| (lock_acq[c] && !lock_acq_d_r[c]) || readapt_r[c];
			// slaves in a broadcast group keep the linear equalizer untouched
			ad_enable[c]  = !xp_path_r[c][`XP_ENABLE_BIT] || xp_path_r[c][`XP_MASTER_BIT];
		end
	end

	for (genvar g = 0; g < NCH; g++) begin : g_adapt
		eq_adapt #(.SETTLE(SETTLE)) u_adapt (
			.clock  (clock),
			.rst_n  (rst_n),
			.start  (ad_start[g]),
			.enable (ad_enable[g]),
			.len_m1 (tbl_len_r[g]),
			.figure_of_merit    (figure_of_merit[g*8 +: 8]),
			.entry  (boost_table[g][ad_idx[g]]),
			.idx    (ad_idx[g]),
			.code   (ad_code[g]),
			.busy   (ad_busy[g]),
			.done   (ad_done[g])
		);
	end

	// each physical equalizer is steered by the channel whose control bus selects it (its own channel if none does),
	// the master winning where several channels select the same one
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			owner[i] = 2'(i);
			owned[i] = 1'b0;
			for (int c = NCH - 1; c >= 0; c--) begin
				if (cbus_sel_r[c][`CBS_HI:`CBS_LO] == 2'(i) && !owned[i]) begin
					owner[i] = 2'(c);
				end
			end
			for (int c = 0; c < NCH; c++) begin
				if (cbus_sel_r[c][`CBS_HI:`CBS_LO] == 2'(i)) begin
					owned[i] = 1'b1;
				end
			end
			for (int c = NCH - 1; c >= 0; c--) begin
				if (cbus_sel_r[c][`CBS_HI:`CBS_LO] == 2'(i) && xp_path_r[c][`XP_MASTER_BIT]) begin
					owner[i] = 2'(c);
				end
			end
		end
	end

	// equalizer and power controls per physical input
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			path_power_on <= '0;
			eq_stage_code <= '0;
			eq_bandwidth  <= '0;
			eq_limiting   <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (owned[i] && sig_det_r[owner[i]][`SD_MANUAL_BIT]) begin
					path_power_on[i] <= sig_det_r[owner[i]][`SD_POWER_ON_BIT];
				end else begin
					path_power_on[i] <= sig_s[i];
				end
				// four stages of two bits each
				eq_stage_code[i*8 +: 8] <= ad_code[owner[i]];
				eq_bandwidth[i*2 +: 2]  <= eq_ctl_r[owner[i]][`EQC_BW_HI:`EQC_BW_LO];
				eq_limiting[i]          <= eq_ctl_r[owner[i]][`EQC_LIMIT_BIT];
			end
		end
	end

	// crosspoint path controls per channel
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_mux_sel        <= '0;
			local_buf_en        <= '0;
			multi_buf_en        <= '0;
			xp_enable           <= '0;
			master_ctl          <= '0;
			recovery_loop_reset <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				// any source of the quad feeds any feedback equalizer
				data_mux_sel[c*2 +: 2] <= xp_path_r[c][`XP_MUX_HI:`XP_MUX_LO];
				local_buf_en[c]        <= xp_path_r[c][`XP_LOCAL_BIT];
				multi_buf_en[c]        <= xp_path_r[c][`XP_MULTI_BIT];
				xp_enable[c]           <= xp_path_r[c][`XP_ENABLE_BIT];
				master_ctl[c]          <= xp_path_r[c][`XP_MASTER_BIT];
				recovery_loop_reset[c] <= rl_rst_now[c];
			end
		end
	end

	// read data selection
	always_comb begin
		rd_value = 8'h00;
		if (reg_addr >= `REG_TABLE_FIRST && reg_addr <= `REG_TABLE_LAST) begin
			rd_value = boost_table[reg_chan][reg_addr[4:0]];
		end else begin
			case (reg_addr)
				`REG_CDR_RESET:    rd_value = cdr_rst_r[reg_chan];
				`REG_SIG_DETECT:   rd_value = sig_det_r[reg_chan];
				`REG_EQ_CONTROL:   rd_value = eq_ctl_r[reg_chan];
				`REG_TABLE_LENGTH: rd_value = {3'h0, tbl_len_r[reg_chan]};
				`REG_XP_PATH:      rd_value = xp_path_r[reg_chan];
				`REG_CTRL_BUS_SEL: rd_value = cbus_sel_r[reg_chan];
				`REG_EQ_STATUS: begin
					rd_value[3:0] = boost_sum(ad_code[reg_chan]);
					rd_value[`STS_DONE_BIT]    = ad_done[reg_chan];
					rd_value[`STS_BUSY_BIT]    = ad_busy[reg_chan];
					rd_value[`STS_POWER_BIT]   = path_power_on[cbus_sel_r[reg_chan][`CBS_HI:`CBS_LO]];
					rd_value[`STS_LOCKACQ_BIT] = lock_acq[reg_chan];
				end
				default: rd_value = 8'h00;
			endcase
		end
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_value;
			end
		end
	end
endmodule

// *** quad_crosspoint_eq_control_assertions.sv ***
// port checker of the quad crosspoint and equalizer control block
`timescale 1ns/10ps
module quad_xp_assertions #(
	parameter int SETTLE = 10
) (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [1:0]  reg_chan,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [3:0]  sig_present,
	input wire logic [3:0]  lock_acq,
	input wire logic [3:0]  path_power_on,
	input wire logic [31:0] eq_stage_code,
	input wire logic [7:0]  data_mux_sel,
	input wire logic [3:0]  local_buf_en,
	input wire logic [3:0]  multi_buf_en,
	input wire logic [3:0]  xp_enable,
	input wire logic [3:0]  master_ctl,
	input wire logic [3:0]  recovery_loop_reset
);
	localparam int QUIET = 32 * (SETTLE + 1) + 16;
	logic [11:0] quiet_r;
	logic [3:0]  manual_r;
	logic [2:0]  auto_r;

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// cycles since anything that may restart or reroute adaptation
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			quiet_r <= 12'h000;
		else if (reg_wr || (lock_acq & ~$past(lock_acq)) != 4'h0 || $changed(sig_present))
			quiet_r <= 12'h000;
		else if (quiet_r != 12'hfff)
			quiet_r <= quiet_r + 12'h001;
	end
	// shadow of the manual gating bits
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			manual_r <= 4'h0;
		else if (reg_wr && reg_addr == 8'h14)
			manual_r[reg_chan] <= reg_wdata[0];
	end
	// cycles with every channel in automatic gating
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			auto_r <= 3'h0;
		else if (manual_r != 4'h0)
			auto_r <= 3'h0;
		else if (auto_r != 3'h7)
			auto_r <= auto_r + 3'h1;
	end

	sequence wr_at(a, c);
		reg_wr && reg_addr == a && reg_chan == c;
	endsequence
	sequence rd_pulse;
		reg_rd ##1 !reg_rd;
	endsequence

	rvalid_pulse_a: assert property (rd_pulse |-> reg_rvalid ##1 !reg_rvalid)
		else $error("read answer is not a single pulse");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {8'h0a, 8'h14, 8'h96, 8'h9b,
		[8'h31:8'h33], [8'h40:8'h5f]}) |=> reg_rdata == 8'h00) else $error("unmapped offset read nonzero");
	readapt_zero_a: assert property (reg_rd && reg_addr == 8'h31 |=> !reg_rdata[3])
		else $error("readapt bit reads back set");
	boost_frozen_a: assert property (quiet_r >= 12'(QUIET) |-> $stable(eq_stage_code))
		else $error("boost moved with no restart");
	for (genvar c = 0; c < 4; c++) begin : ch
		cdr_reset_a: assert property (wr_at(8'h0a, c) |-> ##2
			recovery_loop_reset[c] == |$past(reg_wdata[3:2], 2)) else $error("recovery reset mismatch");
		xp_config_a: assert property (wr_at(8'h96, c) |-> ##2 {data_mux_sel[2*c+:2], master_ctl[c],
			multi_buf_en[c], local_buf_en[c], xp_enable[c]} == $past(reg_wdata[5:0], 2))
			else $error("path config outputs mismatch");
		power_follow_a: assert property (auto_r == 3'h7 |-> path_power_on[c] == $past(sig_present[c], 3))
			else $error("power does not follow energy");
	end
endmodule

bind quad_crosspoint_eq_control quad_xp_assertions #(.SETTLE(SETTLE)) chk (.clock, .reset_n, .reg_wr, .reg_rd,
	.reg_chan, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .sig_present, .lock_acq, .path_power_on,
	.eq_stage_code, .data_mux_sel, .local_buf_en, .multi_buf_en, .xp_enable, .master_ctl, .recovery_loop_reset);

// *** quad_xp_map.svh ***
// register offsets, field positions, reset values and timing constants of the quad control block
`ifndef QUAD_XP_MAP_SVH
`define QUAD_XP_MAP_SVH

// channel register offsets
`define REG_CDR_RESET      8'h0a
`define REG_SIG_DETECT     8'h14
`define REG_EQ_CONTROL     8'h31
`define REG_TABLE_LENGTH   8'h32
`define REG_EQ_STATUS      8'h33
`define REG_TABLE_FIRST    8'h40
`define REG_TABLE_LAST     8'h5f
`define REG_XP_PATH        8'h96
`define REG_CTRL_BUS_SEL   8'h9b

// recovery loop reset bits in cdr_reset_control
`define CDR_RST_LO         2
`define CDR_RST_HI         3
// signal_detect_control fields
`define SD_MANUAL_BIT      0
`define SD_POWER_ON_BIT    1
// eq control fields
`define EQC_BW_LO          0
`define EQC_BW_HI          1
`define EQC_LIMIT_BIT      2
`define EQC_READAPT_BIT    3
// crosspoint_path_config fields
`define XP_ENABLE_BIT      0
`define XP_LOCAL_BIT       1
`define XP_MULTI_BIT       2
`define XP_MASTER_BIT      3
`define XP_MUX_LO          4
`define XP_MUX_HI          5
// control_bus_select field
`define CBS_LO             0
`define CBS_HI             1
// eq status fields
`define STS_DONE_BIT       4
`define STS_BUSY_BIT       5
`define STS_POWER_BIT      6
`define STS_LOCKACQ_BIT    7

// reset values
`define TABLE_LEN_RESET    5'h1f
`define BW_FULL_RATE       2'h0
`define BW_MID_RATE        2'h1
`define BW_HALF_RATE       2'h2
`define TABLE_RESET_ENTRY  8'h00

// settle time after each table step before sampling the figure of merit
`define CLK_PERIOD_NS      10
`define EQ_SETTLE_NS       100
`define EQ_SETTLE_CYC      ((`EQ_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** quad_xp_pkg.sv ***
// shared types and helpers of the quad crosspoint and equalizer control
package quad_xp_pkg;

	typedef enum logic [1:0] {
		ADAPT_IDLE,
		ADAPT_STEP,
		ADAPT_SETTLE,
		ADAPT_FROZEN
	} adapt_state_e;

	typedef logic [7:0] stage_code_t;

	// effective boost level: sum of the four two-bit stage codes
	function automatic logic [3:0] boost_sum(input stage_code_t c);
		boost_sum = {2'h0, c[1:0]} + {2'h0, c[3:2]} + {2'h0, c[5:4]} + {2'h0, c[7:6]};
	endfunction

endpackage

// *** sync2.sv ***
// two flip-flop synchroniser for levels, also used to release the reset
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** test_quad_crosspoint_eq_control.sv ***
// self-checking bench of the quad crosspoint and equalizer control block
`timescale 1ns/10ps
module test_quad_crosspoint_eq_control;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [1:0]  reg_chan = 2'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [3:0]  lock_acq = 4'h0;
	logic [3:0]  active = 4'h0;
	logic [7:0]  reg_rdata, eq_bandwidth, data_mux_sel;
	logic        reg_rvalid;
	logic [3:0]  sig_present, path_power_on, eq_limiting, local_buf_en, multi_buf_en, xp_enable, master_ctl;
	logic [3:0]  recovery_loop_reset;
	logic [31:0] figure_of_merit, eq_stage_code;
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;

	quad_crosspoint_eq_control #(.SETTLE(2)) dut (.clock, .reset_n, .reg_wr, .reg_rd, .reg_chan, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .sig_present, .lock_acq, .figure_of_merit, .path_power_on, .eq_stage_code,
		.eq_bandwidth, .eq_limiting, .data_mux_sel, .local_buf_en, .multi_buf_en, .xp_enable, .master_ctl,
		.recovery_loop_reset);
	link_partner far_end (.active, .eq_stage_code, .sig_present, .figure_of_merit);

	// 100 MHz clock
	always #5 clock = ~clock;
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one register write, strobe dropped and one idle edge after
	task automatic wr(input logic [1:0] c, input logic [7:0] a, d);
		reg_wr <= 1'b1;
		reg_chan <= c;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	// one register read, data taken at the answer edge
	task automatic rd(input logic [1:0] c, input logic [7:0] a, output logic [7:0] d);
		reg_rd <= 1'b1;
		reg_chan <= c;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
	task automatic rdchk(input string n, input logic [1:0] c, input logic [7:0] a, exp);
		logic [7:0] d;
		rd(c, a, d);
		check(n, 32'(d), 32'(exp));
	endtask
	function automatic logic [31:0] bsum(input logic [7:0] x);
		bsum = 32'(x[1:0]) + 32'(x[3:2]) + 32'(x[5:4]) + 32'(x[7:6]);
	endfunction
	// poll channel 0 status until the walk is done, then judge code and level
	task automatic adapt_wait(input string n, input logic [7:0] code);
		logic [7:0] s;
		s = 8'h00;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 100 && s[5:4] != 2'b01; i++)
			rd(2'h0, 8'h33, s);
		check(n, 32'(s[5:4]), 32'h1);
		check(n, 32'(eq_stage_code[7:0]), 32'(code));
		check(n, 32'(s[3:0]), bsum(code));
	endtask

	task automatic defaults_test;
		rdchk("gating mode", 2'h0, 8'h14, 8'h00);
		rdchk("eq control", 2'h1, 8'h31, 8'h00);
		rdchk("table length", 2'h2, 8'h32, 8'h1f);
		rdchk("past table", 2'h3, 8'h60, 8'h00);
		check("bandwidth out", 32'(eq_bandwidth), 32'h00);
		check("mux out", 32'(data_mux_sel), 32'he4);
	endtask
	task automatic table_test;
		for (int i = 0; i < 32; i++)
			wr(2'h1, 8'h40 + 8'(i), 8'(i * 8 + 1));
		for (int i = 0; i < 32; i++)
			rdchk("boost table", 2'h1, 8'h40 + 8'(i), 8'(i * 8 + 1));
	endtask
	task automatic power_test;
		active <= 4'h4;
		repeat (6) @(posedge clock);
		check("power on", 32'(path_power_on), 32'h4);
		wr(2'h2, 8'h14, 8'h01);
		@(posedge clock);
		check("forced off", 32'(path_power_on), 32'h0);
		wr(2'h2, 8'h14, 8'h00);
		active <= 4'h0;
		repeat (6) @(posedge clock);
		check("power off", 32'(path_power_on), 32'h0);
	endtask
	task automatic bw_test;
		for (int b = 0; b < 3; b++) begin
			wr(2'h3, 8'h31, 8'(b + 4 * (b & 1)));
			@(posedge clock);
			check("bandwidth", 32'(eq_bandwidth[7:6]), 32'(b));
			check("limiting", 32'(eq_limiting[3]), 32'(b & 1));
		end
	endtask
	task automatic adapt_test;
		logic [7:0] t[6] = '{8'h01, 8'h55, 8'hf0, 8'h0f, 8'h00, 8'hff};
		for (int i = 0; i < 6; i++)
			wr(2'h0, 8'h40 + 8'(i), t[i]);
		wr(2'h0, 8'h32, 8'h03);
		wr(2'h0, 8'h0a, 8'h0c);
		@(posedge clock);
		check("loop reset", 32'(recovery_loop_reset), 32'h1);
		wr(2'h0, 8'h0a, 8'h00);
		adapt_wait("best of four", 8'hf0);
		wr(2'h0, 8'h40, 8'hfe);
		repeat (60) @(posedge clock);
		check("frozen", 32'(eq_stage_code[7:0]), 32'hf0);
		lock_acq <= 4'h1;
		@(posedge clock);
		lock_acq <= 4'h0;
		adapt_wait("reacquire", 8'hfe);
		wr(2'h0, 8'h40, 8'h01);
		wr(2'h0, 8'h32, 8'h00);
		wr(2'h0, 8'h31, 8'h08);
		adapt_wait("one entry", 8'h01);
	endtask
	// input 0 broadcast to all four outputs, channel 0 master
	task automatic broadcast_test;
		for (int c = 0; c < 4; c++) begin
			wr(2'(c), 8'h9b, 8'h00);
			wr(2'(c), 8'h96, c == 0 ? 8'h0f : 8'h07);
			wr(2'(c), 8'h0a, 8'h0c);
			wr(2'(c), 8'h0a, 8'h00);
		end
		wr(2'h2, 8'h31, 8'h08);
		repeat (40) @(posedge clock);
		check("broadcast mux", 32'(data_mux_sel), 32'h00);
		check("master", 32'(master_ctl), 32'h1);
		check("buffers", 32'({xp_enable, local_buf_en, multi_buf_en}), 32'hfff);
		check("slave hold", 32'(eq_stage_code[7:0]), 32'h01);
		rdchk("slave idle", 2'h2, 8'h33, 8'h00);
	endtask
	// inputs 0 and 1 swapped, the others straight
	task automatic swap_test;
		for (int c = 0; c < 4; c++) begin
			wr(2'(c), 8'h9b, 8'(c ^ (c < 2)));
			wr(2'(c), 8'h96, 8'h07 | 8'((c ^ (c < 2)) << 4));
		end
		wr(2'h1, 8'h31, 8'h01);
		@(posedge clock);
		check("routed bandwidth", 32'(eq_bandwidth), 32'h81);
		check("swap mux", 32'(data_mux_sel), 32'he1);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		defaults_test();
		table_test();
		power_test();
		bw_test();
		adapt_test();
		broadcast_test();
		swap_test();
		report_and_stop();
	end
endmodule
